// ==== tb/adcfs_ctrl_test.sv ====
`timescale 1ns/1ps
module adcfs_ctrl_test;
  import adcfs_pkg::*;
  logic        clk_i, rst_i, cyc, we, trig, ack, irq;  // Clock, reset, bus strobes.
  logic [7:0]  adr, gout, goe, gpu, pout, poe, ppu;    // Address and pad signals.
  logic [31:0] wdat, rdat, dout;                       // Bus data.
  logic [4:0]  sel;                                    // Channel being converted.
  int          mismatches, num_checks, cnt, t0;        // Score and cycle count.
  // Bit 1 of the channel puts its input at the high reference, else at the low one.
  adcfs_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .hw_trig_i(trig), .ain_code_i(12'h800), .ain_high_i(sel[1]),
    .ain_low_i(~sel[1]), .ain_sel_o(sel), .gpio_out_i(gout), .gpio_oe_n_i(goe),
    .gpio_pu_i(gpu), .pad_out_o(pout), .pad_oe_n_o(poe), .pad_pu_o(ppu), .irq_o(irq));
  // The clock runs at 10 MHz.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // A free cycle count lets conversions be timed.
  always @(posedge clk_i) cnt <= cnt + 1;
  // Ends the run with the verdict.
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Compares and counts.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; ack is sampled at the edge, before that edge's updates land.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i iff ack);
    rdat = dout;
    cyc <= 1'b0;
  endtask : bus
  // Polls the completion flag; the watchdog cuts a hang.
  task automatic wait_flag();
    do bus(1'b0, OFF_CHAN, 32'h0); while (rdat[CH_FLAG] !== 1'b1);
  endtask : wait_flag
  // Reset values, and only the defined bits of the two setup registers stick.
  task automatic t_regs();
    for (int a = 0; a <= 8'h20; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk(rdat, 32'h0);
    end
    bus(1'b1, OFF_QCFG, 32'hFF);
    bus(1'b0, OFF_QCFG, 32'h0);
    chk(rdat, 32'h67);
    bus(1'b1, OFF_TRIG, 32'hFF);
    bus(1'b0, OFF_TRIG, 32'h0);
    chk(rdat, 32'h70);
    bus(1'b1, OFF_TRIG, 32'h0);
  endtask : t_regs
  // Four-deep queue in software mode, with interrupt and ordered readout.
  task automatic t_fifo();
    logic [7:0] ch[4] = '{8'h01, 8'h03, 8'h05, 8'h07};
    logic [31:0] ex[4] = '{32'h0, 32'hFF, 32'h0, 32'hFF};
    // Setup follows the fixed order: mask, clock, queue, trigger, then channels.
    bus(1'b1, OFF_IMSK, 32'h1);
    bus(1'b1, OFF_CLK, 32'h0);
    bus(1'b1, OFF_QCFG, 32'h3);
    bus(1'b1, OFF_TRIG, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, OFF_TRIG, 32'h0);
      chk(rdat[TR_BUSY], 1'b0);
      bus(1'b1, OFF_CHAN, {24'h0, ch[i] | 8'h40});
    end
    bus(1'b0, OFF_TRIG, 32'h0);
    chk(rdat[TR_BUSY], 1'b1);
    wait_flag();
    chk(irq, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, OFF_RES, 32'h0);
      chk(rdat, ex[i]);
      if (i == 0) begin
        bus(1'b0, OFF_CHAN, 32'h0);
        chk(rdat[CH_FLAG], 1'b0);
      end
    end
    bus(1'b0, OFF_IST, 32'h0);
    chk(rdat, 32'h1);
    bus(1'b0, OFF_IST, 32'h0);
    chk(rdat, 32'h0);
    chk(irq, 1'b0);
  endtask : t_fifo
  // Single conversions at each resolution; times the whole conversion, sample plus approximation.
  task automatic t_conv(input int m, input int lng);
    int bits, lo;
    bits = 8 + 2 * m;
    lo = (lng != 0 ? 47 : 7) + 2 * bits;
    bus(1'b1, OFF_CLK, 32'(m * 4 + lng * 16));
    bus(1'b1, OFF_QCFG, 32'h0);
    bus(1'b1, OFF_CHAN, 32'h03);
    t0 = cnt;
    wait_flag();
    chk(32'(cnt - t0 >= lo && cnt - t0 <= lo + 12), 32'h1);
    bus(1'b0, OFF_RES, 32'h0);
    chk(rdat, (32'h1 << bits) - 1);
    bus(1'b1, OFF_CHAN, 32'h04);
    wait_flag();
    bus(1'b0, OFF_RES, 32'h0);
    chk(rdat, 32'h0);
  endtask : t_conv
  // Analog select takes the pad away from the digital port.
  task automatic t_pins();
    gout <= 8'hFF;
    goe  <= 8'h00;
    gpu  <= 8'hFF;
    bus(1'b1, OFF_PIN, 32'h0F);
    repeat (2) @(posedge clk_i);
    chk({8'h0, poe, ppu, pout}, 32'h000FF0F0);
  endtask : t_pins
  // Hardware trigger: one conversion per trigger edge.
  task automatic t_hw();
    // Fast 8-bit conversions, so each one ends well inside the trigger gap.
    bus(1'b1, OFF_CLK, 32'h0);
    bus(1'b1, OFF_QCFG, 32'h1);
    bus(1'b1, OFF_TRIG, 32'h40);
    bus(1'b1, OFF_CHAN, 32'h01);
    bus(1'b1, OFF_CHAN, 32'h03);
    for (int k = 0; k < 2; k++) begin
      repeat (80) @(posedge clk_i);
      bus(1'b0, OFF_CHAN, 32'h0);
      chk(rdat[CH_FLAG], 1'b0);
      trig <= 1'b1;
      repeat (4) @(posedge clk_i);
      trig <= 1'b0;
    end
    wait_flag();
    bus(1'b0, OFF_RES, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, OFF_RES, 32'h0);
    chk(rdat, 32'hFF);
  endtask : t_hw
  // Eight-deep queue: nothing runs until the eighth entry is in.
  task automatic t_deep();
    bus(1'b1, OFF_QCFG, 32'h7);
    bus(1'b1, OFF_TRIG, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, OFF_TRIG, 32'h0);
      chk(rdat[TR_BUSY], 1'b0);
      bus(1'b1, OFF_CHAN, 32'(i));
    end
    wait_flag();
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, OFF_RES, 32'h0);
      chk(rdat, (i & 2) != 0 ? 32'hFF : 32'h0);
    end
  endtask : t_deep
  // Main sequence: reset for 20 cycles, then each scenario.
  initial begin
    rst_i      = 1'b1;
    cyc        = 1'b0;
    we         = 1'b0;
    trig       = 1'b0;
    adr        = 8'h00;
    wdat       = 32'h0;
    gout       = 8'h00;
    goe        = 8'hFF;
    gpu        = 8'h00;
    cnt        = 0;
    mismatches = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_fifo();
    t_deep();
    for (int m = 0; m < 3; m++) t_conv(m, 0);
    t_conv(2, 1);
    t_pins();
    t_hw();
    wrap_up();
  end
  // Watchdog: the whole run needs far fewer than 50000 cycles.
  initial begin
    #5000000;
    mismatches++;
    wrap_up();
  end
endmodule : adcfs_ctrl_test

// ==== verilog/adcfs_ctrl.sv ====
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
module adcfs_ctrl (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Trigger and analog front end.
  input  wire logic        hw_trig_i,
  input  wire logic [11:0] ain_code_i,
  input  wire logic        ain_high_i,
  input  wire logic        ain_low_i,
  output logic [4:0]       ain_sel_o,
  // Pad control of the shared pins.
  input  wire logic [7:0]  gpio_out_i,
  input  wire logic [7:0]  gpio_oe_n_i,
  input  wire logic [7:0]  gpio_pu_i,
  output logic [7:0]       pad_out_o,
  output logic [7:0]       pad_oe_n_o,
  output logic [7:0]       pad_pu_o,
  // Interrupt.
  output logic             irq_o
);
  import adcfs_pkg::*;

  // Two-flop synchronisers for pin inputs; stage one feeds stage two only.
  logic [14:0] sync1_r, sync2_r;
  logic        trig_d_r;          // Previous synchronised trigger level.
  logic        trig_edge;         // Rising trigger, one cycle.

  // Conversion clock divider.
  logic [7:0]  div_cnt_r, div_cnt_nxt;
  logic        half_tick_r, half_tick_nxt;
  logic [7:0]  div_top;

  // Software-visible registers.
  logic [7:0]  trig_r, trig_nxt;  // Trigger control.
  logic [7:0]  clk_r, clk_nxt;    // Clock configuration.
  logic [7:0]  qcfg_r, qcfg_nxt;  // Queue configuration.
  logic [7:0]  pin_r, pin_nxt;    // Pin analog select.
  logic        cont_r, cont_nxt;  // Continuous select.
  logic        ien_r, ien_nxt;    // Completion interrupt enable.
  logic        flag_r, flag_nxt;  // Conversion complete flag.
  logic [1:0]  ist_r, ist_nxt;    // Sticky interrupt status.
  logic [1:0]  imsk_r, imsk_nxt;  // Interrupt mask.

  // Queues and sequencing state.
  logic [4:0]  chq_r  [QDEPTH_MAX];
  logic [4:0]  chq_nxt [QDEPTH_MAX];
  logic [15:0] resq_r [QDEPTH_MAX];
  logic [15:0] resq_nxt [QDEPTH_MAX];
  adcfs_state_e state_r, state_nxt;
  logic [3:0]  wcnt_r, wcnt_nxt;  // Channels written.
  logic [2:0]  fidx_r, fidx_nxt;  // Next channel to fetch.
  logic [3:0]  dcnt_r, dcnt_nxt;  // Results stored.
  logic [2:0]  ridx_r, ridx_nxt;  // Next result to read.
  logic [4:0]  sel_nxt;
  logic        start_r, start_nxt;
  logic        abort_r, abort_nxt;

  // Bus side.
  logic [31:0] dat_nxt, rdata;
  logic        req, wr, chan_wr, res_rd, ist_rd;
  logic [7:0]  off;
  logic        flag_set, lost_set, irq_nxt;
  logic [7:0]  pout_nxt, poe_nxt, ppu_nxt;

  // Decoded configuration.
  logic [2:0]  dcode;
  logic [3:0]  depth;
  logic        scan, hw, full;
  logic        eng_done;
  logic [15:0] eng_result;

  // The analog level is slow against the sample window, so a plain
  // double flop per bit is enough; a code may mix two levels at a step.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r  <= 15'h0000;
      sync2_r  <= 15'h0000;
      trig_d_r <= 1'b0;
    end else begin
      sync1_r  <= {hw_trig_i, ain_high_i, ain_low_i, ain_code_i};
      sync2_r  <= sync1_r;
      trig_d_r <= sync2_r[14];
    end
  end
  assign trig_edge = sync2_r[14] && !trig_d_r;

  // Half-cycle tick of the conversion clock, every 2**div bus cycles.
  always_comb begin
    div_top       = (8'h01 << clk_r[CK_DIV_LSB +: 2]) - 8'h01;
    half_tick_nxt = (div_cnt_r == div_top);
    div_cnt_nxt   = half_tick_nxt ? 8'h00 : div_cnt_r + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r   <= 8'h00;
      half_tick_r <= 1'b0;
    end else begin
      div_cnt_r   <= div_cnt_nxt;
      half_tick_r <= half_tick_nxt;
    end
  end

  // Configuration decode; a zero depth code is the plain single-channel mode, with scan off.
  assign dcode = qcfg_r[QC_DEPTH_LSB +: 3];
  assign depth = {1'b0, dcode} + 4'd1;
  assign scan  = qcfg_r[QC_SCAN] && (dcode != 3'd0);
  assign hw    = trig_r[TR_HW];
  assign full  = scan ? (wcnt_r != 4'd0) : (wcnt_r >= depth);

  // Bus request is taken once; ack follows in the next cycle.
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign off     = {wb_adr_i[7:2], 2'b00};
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign chan_wr = wr && (off == OFF_CHAN);
  assign res_rd  = req && !wb_we_i && (off == OFF_RES);
  assign ist_rd  = req && !wb_we_i && (off == OFF_IST);

  // Read data; unmapped words read as zero.
  always_comb begin
    case (off)
      OFF_CHAN: rdata = {24'h0, flag_r, ien_r, cont_r, ain_sel_o};
      OFF_TRIG: rdata = {24'h0, trig_r | {4'h0, state_r == ST_CONV ||
                                           state_r == ST_WAIT, 3'h0}};
      OFF_CLK:  rdata = {24'h0, clk_r};
      OFF_QCFG: rdata = {24'h0, qcfg_r};
      OFF_RES:  rdata = {16'h0, resq_r[ridx_r]};
      OFF_PIN:  rdata = {24'h0, pin_r};
      OFF_IST:  rdata = {30'h0, ist_r};
      OFF_IMSK: rdata = {30'h0, imsk_r};
      default:  rdata = 32'h0;
    endcase
  end

  // Sequencer, register writes and read side effects.
  always_comb begin
    state_nxt = state_r;
    chq_nxt   = chq_r;
    resq_nxt  = resq_r;
    wcnt_nxt  = wcnt_r;
    fidx_nxt  = fidx_r;
    dcnt_nxt  = dcnt_r;
    ridx_nxt  = ridx_r;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    flag_set  = 1'b0;
    lost_set  = 1'b0;
    trig_nxt  = trig_r;
    clk_nxt   = clk_r;
    qcfg_nxt  = qcfg_r;
    pin_nxt   = pin_r;
    cont_nxt  = cont_r;
    ien_nxt   = ien_r;
    imsk_nxt  = imsk_r;
    case (state_r)
      ST_FILL: begin
        // Nothing starts until the queue is full, whatever the trigger.
        if (full) begin
          fidx_nxt  = 3'd0;
          dcnt_nxt  = 4'd0;
          ridx_nxt  = 3'd0;
          state_nxt = hw ? ST_WAIT : ST_CONV;
          start_nxt = !hw;
        end
      end
      ST_WAIT: begin
        if (trig_edge) begin
          state_nxt = ST_CONV;
          start_nxt = 1'b1;
        end
      end
      ST_CONV: begin
        // A trigger during a conversion is dropped and reported.
        lost_set = hw && trig_edge;
        if (eng_done) begin
          resq_nxt[dcnt_r[2:0]] = eng_result;
          if (dcnt_r + 4'd1 == depth) begin
            flag_set  = 1'b1;
            fidx_nxt  = 3'd0;
            dcnt_nxt  = 4'd0;
            ridx_nxt  = 3'd0;
            state_nxt = !cont_r ? ST_DONE : (hw ? ST_WAIT : ST_CONV);
            start_nxt = cont_r && !hw;
          end else begin
            dcnt_nxt  = dcnt_r + 4'd1;
            fidx_nxt  = fidx_r + 3'd1;
            state_nxt = hw ? ST_WAIT : ST_CONV;
            start_nxt = !hw;
          end
        end
      end
      ST_DONE: begin
        // A single sequence rests until a refill or a new trigger.
        if (hw && trig_edge) begin
          state_nxt = ST_CONV;
          start_nxt = 1'b1;
        end
      end
      default: state_nxt = ST_FILL;
    endcase
    if (wr) begin
      case (off)
        OFF_CHAN: begin
          cont_nxt = wb_dat_i[CH_CONT];
          ien_nxt  = wb_dat_i[CH_IEN];
          if (state_r != ST_FILL) begin
            // Any write while busy or done aborts and starts a new fill.
            abort_nxt  = 1'b1;
            start_nxt  = 1'b0;
            state_nxt  = ST_FILL;
            chq_nxt[0] = wb_dat_i[CH_SEL_LSB +: 5];
            wcnt_nxt   = 4'd1;
          end else if (scan && wcnt_r != 4'd0) begin
            chq_nxt[0] = wb_dat_i[CH_SEL_LSB +: 5];
          end else if (wcnt_r < depth) begin
            chq_nxt[wcnt_r[2:0]] = wb_dat_i[CH_SEL_LSB +: 5];
            wcnt_nxt = wcnt_r + 4'd1;
          end
        end
        OFF_TRIG: trig_nxt = wb_dat_i[7:0] & TRIG_WMASK;
        OFF_CLK:  clk_nxt  = wb_dat_i[7:0];
        OFF_QCFG: qcfg_nxt = wb_dat_i[7:0] & QCFG_WMASK;
        OFF_PIN:  pin_nxt  = wb_dat_i[7:0];
        OFF_IMSK: imsk_nxt = wb_dat_i[1:0];
        default: begin
        end
      endcase
    end
    // Reads walk the result queue in fill order.
    if (res_rd) begin
      ridx_nxt = (ridx_r + 3'd1 == depth[2:0]) ? 3'd0 : ridx_r + 3'd1;
    end
    // Hardware sets win over clears made in the same cycle.
    flag_nxt = flag_set ? 1'b1 : (res_rd ? 1'b0 : flag_r);
    ist_nxt  = (ist_rd ? 2'b00 : ist_r) | {lost_set, flag_set && ien_r};
    // The channel is taken from the queue whatever the pin select says.
    sel_nxt  = ain_sel_o;
    if (start_nxt) begin
      sel_nxt = scan ? chq_r[0] : chq_r[fidx_nxt];
    end
    irq_nxt  = |(ist_r & imsk_r);
    dat_nxt  = (req && !wb_we_i) ? rdata : 32'h0;
    // Analog pins lose their driver and pullup.
    pout_nxt = gpio_out_i & ~pin_r;
    poe_nxt  = gpio_oe_n_i | pin_r;
    ppu_nxt  = gpio_pu_i & ~pin_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_FILL;
      wcnt_r     <= 4'd0;
      fidx_r     <= 3'd0;
      dcnt_r     <= 4'd0;
      ridx_r     <= 3'd0;
      start_r    <= 1'b0;
      abort_r    <= 1'b0;
      trig_r     <= RST_REG;
      clk_r      <= RST_REG;
      qcfg_r     <= RST_REG;
      pin_r      <= RST_REG;
      cont_r     <= 1'b0;
      ien_r      <= 1'b0;
      flag_r     <= 1'b0;
      ist_r      <= 2'b00;
      imsk_r     <= 2'b00;
      ain_sel_o  <= 5'h00;
      irq_o      <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
      pad_out_o  <= 8'h00;
      pad_oe_n_o <= 8'hFF;
      pad_pu_o   <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      chq_r      <= chq_nxt;
      resq_r     <= resq_nxt;
      wcnt_r     <= wcnt_nxt;
      fidx_r     <= fidx_nxt;
      dcnt_r     <= dcnt_nxt;
      ridx_r     <= ridx_nxt;
      start_r    <= start_nxt;
      abort_r    <= abort_nxt;
      trig_r     <= trig_nxt;
      clk_r      <= clk_nxt;
      qcfg_r     <= qcfg_nxt;
      pin_r      <= pin_nxt;
      cont_r     <= cont_nxt;
      ien_r      <= ien_nxt;
      flag_r     <= flag_nxt;
      ist_r      <= ist_nxt;
      imsk_r     <= imsk_nxt;
      ain_sel_o  <= sel_nxt;
      irq_o      <= irq_nxt;
      wb_ack_o   <= req;
      wb_dat_o   <= dat_nxt;
      pad_out_o  <= pout_nxt;
      pad_oe_n_o <= poe_nxt;
      pad_pu_o   <= ppu_nxt;
    end
  end

  // Converter engine; it starts one cycle after the channel is selected.
  adcfs_sar u_sar (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .half_tick_i (half_tick_r),
    .start_i     (start_r),
    .abort_i     (abort_r),
    .long_i      (clk_r[CK_LONG]),
    .mode_i      (clk_r[CK_MODE_LSB +: 2]),
    .code_i      (sync2_r[11:0]),
    .at_high_i   (sync2_r[13]),
    .at_low_i    (sync2_r[12]),
    .done_o      (eng_done),
    .result_o    (eng_result)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wait_full: assert property ((state_r == ST_FILL && !full) |=> state_r == ST_FILL)
    else $error("sequence started on a short queue");
  a_fourth_starts: assert property ((state_r == ST_FILL && !scan && !hw && dcode == 3'd3
    && wcnt_r == 4'd3 && chan_wr) ##1 !chan_wr |=> state_r == ST_CONV && start_r)
    else $error("fourth channel write did not start");
  a_read_clears: assert property ((res_rd && !flag_set) |=> !flag_r)
    else $error("result read left flag set");
  a_result_order: assert property (res_rd |=> wb_dat_o[15:0] == $past(resq_r[ridx_r])
    && ridx_r != $past(ridx_r) || depth == 4'd1)
    else $error("result queue not walked in order");
  a_flag_all_done: assert property ($rose(flag_r) |-> $past(dcnt_r) + 4'd1 == depth
    && $past(eng_done))
    else $error("flag set before whole queue");
  a_hw_holds: assert property ((state_r == ST_WAIT && !trig_edge && !chan_wr)
    |=> state_r == ST_WAIT && !start_r)
    else $error("fetched without hardware trigger");
  a_pad_hiz: assert property (1'b1 |=> ((pad_oe_n_o & $past(pin_r)) == $past(pin_r))
    && ((pad_pu_o & $past(pin_r)) == 8'h00))
    else $error("analog pin still driven");
  a_irq_level: assert property (1'b1 |=> irq_o == |($past(ist_r & imsk_r)))
    else $error("interrupt output wrong");

  c_queue_done: cover property ($rose(flag_r) && depth == 4'd4);
  c_hw_trigger: cover property (state_r == ST_WAIT ##1 state_r == ST_CONV);
  c_abort_refill: cover property (abort_r ##1 state_r == ST_FILL);
  c_lost_trig: cover property (lost_set);

endmodule : adcfs_ctrl

// ==== verilog/adcfs_pkg.sv ====
package adcfs_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFF_CHAN = 8'h00;  // Channel and status register.
  localparam logic [7:0] OFF_TRIG = 8'h04;  // Trigger control register.
  localparam logic [7:0] OFF_CLK  = 8'h08;  // Clock configuration register.
  localparam logic [7:0] OFF_QCFG = 8'h0C;  // Queue configuration register.
  localparam logic [7:0] OFF_RES  = 8'h10;  // Sixteen-bit result word.
  localparam logic [7:0] OFF_PIN  = 8'h14;  // Pin analog control register.
  localparam logic [7:0] OFF_IST  = 8'h18;  // Interrupt status, cleared by read.
  localparam logic [7:0] OFF_IMSK = 8'h1C;  // Interrupt mask.

  // Channel and status register fields.
  localparam int CH_SEL_LSB = 0;  // Input channel select, five bits.
  localparam int CH_CONT    = 5;  // Continuous select.
  localparam int CH_IEN     = 6;  // Completion interrupt enable.
  localparam int CH_FLAG    = 7;  // Conversion complete flag, read only.

  // Trigger control fields.
  localparam int TR_BUSY   = 3;  // Sequence running, read only.
  localparam int TR_CMP_GT = 4;  // Compare greater-than option.
  localparam int TR_CMP_EN = 5;  // Compare enable.
  localparam int TR_HW     = 6;  // Hardware trigger select.
  localparam logic [7:0] TRIG_WMASK = 8'h70;

  // Clock configuration fields.
  localparam int CK_SRC_LSB  = 0;  // Clock source, two bits.
  localparam int CK_MODE_LSB = 2;  // Resolution: 0 8-bit, 1 10-bit, else 12-bit.
  localparam int CK_LONG     = 4;  // Long sample select.
  localparam int CK_DIV_LSB  = 5;  // Divider, two bits.
  localparam int CK_LOWPOW   = 7;  // Low power select.

  // Queue configuration fields.
  localparam int QC_DEPTH_LSB = 0;  // Depth code, three bits.
  localparam int QC_AND       = 5;  // Compare combining: 1 AND, 0 OR.
  localparam int QC_SCAN      = 6;  // Queue scan enable.
  localparam logic [7:0] QCFG_WMASK = 8'h67;

  // Interrupt status bits.
  localparam int IRQ_DONE = 0;  // Whole queue converted.
  localparam int IRQ_LOST = 1;  // Hardware trigger arrived during a conversion.

  localparam logic [7:0] RST_REG    = 8'h00;  // Reset value of the trigger, clock, queue and pin registers.
  localparam int         QDEPTH_MAX = 8;      // Queue entries.

  // Sample lengths in tenths of a conversion clock cycle.
  localparam int SAMP_SHORT_TENTHS = 35;
  localparam int SAMP_LONG_TENTHS  = 235;
  // The same lengths in conversion clock half cycles.
  localparam logic [5:0] SAMP_SHORT_HALF = 6'(SAMP_SHORT_TENTHS * 2 / 10);
  localparam logic [5:0] SAMP_LONG_HALF  = 6'(SAMP_LONG_TENTHS * 2 / 10);

  typedef enum logic [1:0] {ST_FILL, ST_WAIT, ST_CONV, ST_DONE} adcfs_state_e;

  // Number of result bits for a resolution code.
  function automatic logic [3:0] adcfs_bits(input logic [1:0] mode);
    case (mode)
      2'h0:    adcfs_bits = 4'd8;
      2'h1:    adcfs_bits = 4'd10;
      default: adcfs_bits = 4'd12;
    endcase
  endfunction : adcfs_bits

  // Full-scale code for a resolution code.
  function automatic logic [11:0] adcfs_full(input logic [1:0] mode);
    case (mode)
      2'h0:    adcfs_full = 12'h0FF;
      2'h1:    adcfs_full = 12'h3FF;
      default: adcfs_full = 12'hFFF;
    endcase
  endfunction : adcfs_full

endpackage : adcfs_pkg

// ==== verilog/adcfs_sar.sv ====
`timescale 1ns/1ps
module adcfs_sar (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control from the sequencer.
  input  wire logic        half_tick_i,
  input  wire logic        start_i,
  input  wire logic        abort_i,
  input  wire logic        long_i,
  input  wire logic [1:0]  mode_i,
  // Synchronised analog level.
  input  wire logic [11:0] code_i,
  input  wire logic        at_high_i,
  input  wire logic        at_low_i,
  // Result.
  output logic             done_o,
  output logic [15:0]      result_o
);
  import adcfs_pkg::*;

  typedef enum logic [1:0] {ENG_IDLE, ENG_SAMP, ENG_CONV} adcfs_eng_e;

  adcfs_eng_e  st_r, st_nxt;      // Engine phase.
  logic [5:0]  cnt_r, cnt_nxt;    // Half cycles spent in the phase.
  logic        done_nxt;          // Completion pulse.
  logic [15:0] res_nxt;           // Captured code.
  logic [5:0]  samp_len;          // Sample phase in half cycles.
  logic [5:0]  conv_len;          // Approximation phase in half cycles.
  logic [3:0]  bits;              // Result width.
  logic [5:0]  samp_ticks_r;      // Independent count, read only by checks.

  // Phase sequencing; the level is frozen when sampling ends.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    res_nxt  = result_o;
    bits     = adcfs_bits(mode_i);
    samp_len = long_i ? SAMP_LONG_HALF : SAMP_SHORT_HALF;
    conv_len = {1'b0, bits, 1'b0};
    case (st_r)
      ENG_IDLE: begin
      end
      ENG_SAMP: begin
        if (half_tick_i) begin
          if (cnt_r == samp_len - 6'd1) begin
            st_nxt  = ENG_CONV;
            cnt_nxt = 6'd0;
            // Out-of-range levels saturate instead of wrapping.
            if (at_high_i) begin
              res_nxt = {4'h0, adcfs_full(mode_i)};
            end else if (at_low_i) begin
              res_nxt = 16'h0000;
            end else begin
              res_nxt = {4'h0, code_i >> (4'd12 - bits)};
            end
          end else begin
            cnt_nxt = cnt_r + 6'd1;
          end
        end
      end
      ENG_CONV: begin
        if (half_tick_i) begin
          if (cnt_r == conv_len - 6'd1) begin
            st_nxt   = ENG_IDLE;
            done_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 6'd1;
          end
        end
      end
      default: st_nxt = ENG_IDLE;
    endcase
    // An abort drops the conversion; a start always restarts sampling.
    if (abort_i) begin
      st_nxt   = ENG_IDLE;
      done_nxt = 1'b0;
    end
    if (start_i) begin
      st_nxt  = ENG_SAMP;
      cnt_nxt = 6'd0;
    end
  end

  // Engine registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r         <= ENG_IDLE;
      cnt_r        <= 6'd0;
      done_o       <= 1'b0;
      result_o     <= 16'h0000;
      samp_ticks_r <= 6'd0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      done_o   <= done_nxt;
      result_o <= res_nxt;
      if (start_i) begin
        samp_ticks_r <= 6'd0;
      end else if (st_r == ENG_SAMP && half_tick_i) begin
        samp_ticks_r <= samp_ticks_r + 6'd1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sample_len: assert property ((st_r == ENG_SAMP && st_nxt == ENG_CONV)
    |-> samp_ticks_r + 6'd1 == samp_len)
    else $error("sample phase length wrong");
  a_full_scale: assert property ((st_r == ENG_SAMP && st_nxt == ENG_CONV
    && at_high_i && !start_i) |=> result_o == {4'h0, adcfs_full($past(mode_i))})
    else $error("high input not full scale");
  a_zero_code: assert property ((st_r == ENG_SAMP && st_nxt == ENG_CONV
    && at_low_i && !at_high_i && !start_i) |=> result_o == 16'h0000)
    else $error("low input not zero");

endmodule : adcfs_sar
